// file: src/lseg_pkg.sv
// Constants shared by the line status event generator.
// Assumes a 100 MHz master clock and a 32-bit AXI4-Lite register bus.
package lseg_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] LSEG_IDX_MASK = 6'h14;
   localparam logic [5:0] LSEG_IDX_EDGE_SEL = 6'h16;
   localparam logic [5:0] LSEG_IDX_STATUS = 6'h17;
   localparam logic [5:0] LSEG_IDX_INT_STATUS = 6'h19;
   localparam logic [5:0] LSEG_IDX_CTRL = 6'h20;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int LSEG_NSRC = 7;
   localparam int LSEG_BIT_LOS = 0;
   localparam int LSEG_BIT_AIS = 1;
   localparam int LSEG_BIT_DF = 2;
   localparam int LSEG_BIT_TRANSMIT_CLOCK = 3;
   localparam int LSEG_BIT_PRBS = 4;
   localparam int LSEG_BIT_DEACT = 5;
   localparam int LSEG_BIT_ACT = 6;
   localparam int LSEG_CTRL_AUTO_REMOTE_LOOP_ENABLE = 0;
   localparam int LSEG_CTRL_RLP = 1;
   localparam logic [6:0] LSEG_MASK_RESET = 7'h7f;
   localparam logic [6:0] LSEG_EDGE_SEL_RESET = 7'h00;
   localparam logic [6:0] LSEG_STATUS_RESET = 7'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint LSEG_CLK_HZ = 100000000;
   localparam longint LSEG_QUAL_SHORT_MS = 40;
   localparam longint LSEG_QUAL_LONG_MS = 5100;
   localparam int unsigned LSEG_QUAL_SHORT_CYC = 32'(LSEG_QUAL_SHORT_MS * LSEG_CLK_HZ / 1000);
   localparam int unsigned LSEG_QUAL_LONG_CYC = 32'(LSEG_QUAL_LONG_MS * LSEG_CLK_HZ / 1000);
   // Seventy master clock cycles without a transmit clock change
   localparam logic [7:0] LSEG_TRANSMIT_CLOCK_LOSS_CYC = 8'h46;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] LSEG_RESP_OKAY = 2'b00;
   localparam logic [1:0] LSEG_RESP_SLVERR = 2'b10;

endpackage

// file: src/lseg_top.sv
// Line status monitor and interrupt event generator, AXI4-Lite slave.
// Assumes detector levels arrive asynchronously on pins; all are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module lseg_top
   import lseg_pkg::*;
#(
   parameter int unsigned QUAL_SHORT_CYCLES = LSEG_QUAL_SHORT_CYC,
   parameter int unsigned QUAL_LONG_CYCLES = LSEG_QUAL_LONG_CYC,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Detector levels, asynchronous
   input wire logic activate_code_seen,
   input wire logic deactivate_code_seen,
   input wire logic code_error_rate_high,
   input wire logic pattern_sync_in,
   input wire logic transmit_clock,
   input wire logic driver_short_in,
   input wire logic alarm_indication_in,
   input wire logic receive_line_pair_loss,
   // Results
   output logic irq,
   output logic remote_loop_active,
   output logic [6:0] line_status
);

   // ----------------------------------------------------------------
   // Register map (byte address is four times the index, one word each)
   // ----------------------------------------------------------------
   // 0x50 mask, read/write, resets to 0x7f; a 0 bit lets that source interrupt
   // 0x58 edge select, read/write, resets to 0x00; 0 rising only, 1 both ways
   // 0x5c line status, read only, the real-time image below
   // 0x64 interrupt status, read only; a read returns and clears the latch
   // 0x80 control: bit 0 auto remote loop enable, bit 1 remote loop (read only)
   // Any other word answers with a slave error and reads as zero.
   // Writes to the two read-only words are dropped with an okay response, so
   // software that writes back a whole block sees no spurious errors.
   //
   // Bit layout shared by mask, edge select, line status and interrupt status:
   //    6  activate code detected
   //    5  deactivate code detected
   //    4  pattern sync
   //    3  transmit clock missing
   //    2  driver fail
   //    1  alarm indication
   //    0  signal loss
   // Bits 31:7 read as zero and are ignored on write; only byte lane 0 has effect.

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // Synchroniser lanes:
   //    0 signal loss
   //    1 alarm indication
   //    2 driver short
   //    3 pattern sync
   //    4 transmit clock
   //    5 activate code
   //    6 deactivate code
   //    7 code error rate
   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic transmit_clock_prev;
      logic [7:0] transmit_clock_cnt;
      logic [1:0][31:0] qual_cnt;
      logic [6:0] status;
      logic [6:0] status_prev;
      logic [6:0] edge_sel;
      logic [6:0] mask;
      logic [6:0] int_status;
      logic auto_remote_loop_enable;
      logic rloop;
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lseg_state_t;

   lseg_state_t st_q;
   lseg_state_t st_d;

   localparam lseg_state_t LSEG_STATE_RESET = '{
      sync1: 8'h00,
      sync2: 8'h00,
      transmit_clock_prev: 1'b0,
      transmit_clock_cnt: 8'h00,
      qual_cnt: '0,
      status: LSEG_STATUS_RESET,
      status_prev: LSEG_STATUS_RESET,
      edge_sel: LSEG_EDGE_SEL_RESET,
      mask: LSEG_MASK_RESET,
      int_status: 7'h00,
      auto_remote_loop_enable: 1'b0,
      rloop: 1'b0,
      aw_held: 1'b0,
      awaddr: '0,
      w_held: 1'b0,
      wdata: 32'h0000_0000,
      wstrb: 4'h0,
      bvalid: 1'b0,
      bresp: LSEG_RESP_OKAY,
      rvalid: 1'b0,
      rdata: 32'h0000_0000,
      rresp: LSEG_RESP_OKAY};

   logic [7:0] raw_in;
   assign raw_in = {code_error_rate_high, deactivate_code_seen, activate_code_seen, transmit_clock,
                    pattern_sync_in, driver_short_in, alarm_indication_in, receive_line_pair_loss};

   // ----------------------------------------------------------------
   // Edge events
   // ----------------------------------------------------------------
   // One lane per source; a masked source never reaches the latch, so
   // unmasking later cannot replay an old transition.
   logic [6:0] src_rise;
   logic [6:0] src_change;
   logic [6:0] src_event;
   for (genvar g = 0; g < LSEG_NSRC; g++) begin : g_edge
      assign src_rise[g] = st_q.status[g] & ~st_q.status_prev[g];
      assign src_change[g] = st_q.status[g] ^ st_q.status_prev[g];
      assign src_event[g] = (st_q.edge_sel[g] ? src_change[g] : src_rise[g]) & ~st_q.mask[g];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] qual_limit;
      logic [1:0] code_st;
      logic [6:0] rise;
      logic [6:0] event_v;
      logic [5:0] widx;
      logic [5:0] ridx;
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      qual_limit = 32'h0;
      code_st = 2'b00;
      rise = 7'h00;
      event_v = 7'h00;
      widx = 6'h00;
      ridx = 6'h00;
      aw_hs = 1'b0;
      w_hs = 1'b0;
      ar_hs = 1'b0;
      st_d = st_q;

      // Two-stage synchronisers; stage one feeds only stage two
      st_d.sync1 = raw_in;
      st_d.sync2 = st_q.sync1;

      // Transmit clock activity watchdog, saturating one past the limit
      // The pin is sampled, not used as a clock: toggles faster than half
      // the master clock are not seen, which the loss rule tolerates.
      st_d.transmit_clock_prev = st_q.sync2[4];
      if (st_q.sync2[4] != st_q.transmit_clock_prev) begin
         st_d.transmit_clock_cnt = 8'h00;
      end else if (st_q.transmit_clock_cnt <= LSEG_TRANSMIT_CLOCK_LOSS_CYC) begin
         st_d.transmit_clock_cnt = st_q.transmit_clock_cnt + 8'd1;
      end

      // Inband code qualification; the long window applies with auto loopback
      // Counters saturate one past the limit so a long code never wraps back
      // to an unqualified count.
      // One shared error-rate flag clears both code bits; a code that drops
      // with the error rate still low keeps its status, as the hold rule asks.
      qual_limit = st_q.auto_remote_loop_enable ? QUAL_LONG_CYCLES : QUAL_SHORT_CYCLES;
      for (int i = 0; i < 2; i++) begin
         code_st[i] = st_q.status[LSEG_BIT_ACT - i];
         if (!st_q.sync2[5 + i] || st_q.sync2[7]) begin
            st_d.qual_cnt[i] = 32'h0;
         end else if (st_q.qual_cnt[i] <= qual_limit) begin
            st_d.qual_cnt[i] = st_q.qual_cnt[i] + 32'd1;
         end
         if (st_q.sync2[7]) begin
            code_st[i] = 1'b0;
         end else if (st_q.qual_cnt[i] > qual_limit) begin
            code_st[i] = 1'b1;
         end
      end

      // Real-time status register image
      st_d.status[LSEG_BIT_ACT] = code_st[0];
      st_d.status[LSEG_BIT_DEACT] = code_st[1];
      st_d.status[LSEG_BIT_PRBS] = st_q.sync2[3];
      st_d.status[LSEG_BIT_TRANSMIT_CLOCK] = (st_q.transmit_clock_cnt > LSEG_TRANSMIT_CLOCK_LOSS_CYC);
      st_d.status[LSEG_BIT_DF] = st_q.sync2[2];
      st_d.status[LSEG_BIT_AIS] = st_q.sync2[1];
      st_d.status[LSEG_BIT_LOS] = st_q.sync2[0];

      // Edge events against last cycle's status
      st_d.status_prev = st_q.status;
      rise = src_rise;
      event_v = src_event;

      // Remote loopback follows code detection; deactivate wins a tie
      // The loop state is held until the opposite code qualifies; codes that
      // merely go away leave it as it is.
      if (rise[LSEG_BIT_DEACT]) begin
         st_d.rloop = 1'b0;
      end else if (rise[LSEG_BIT_ACT]) begin
         st_d.rloop = 1'b1;
      end

      // Write channel capture, either order
      // A half that arrives alone is parked until its partner comes; readies
      // stay low while the response is pending, which keeps at most one
      // write in flight.
      aw_hs = s_axi_awvalid && !st_q.aw_held && !st_q.bvalid;
      w_hs = s_axi_wvalid && !st_q.w_held && !st_q.bvalid;
      if (aw_hs) begin
         st_d.aw_held = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
         st_d.w_held = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end

      // Perform write once both halves are held
      if (st_q.aw_held && st_q.w_held) begin
         // Index from the word address; byte offsets within the word are
         // ignored, as every register is one aligned word.
         widx = st_q.awaddr[ADDR_W-1:2];
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = LSEG_RESP_OKAY;
         case (widx)
            LSEG_IDX_MASK: begin
               if (st_q.wstrb[0]) begin
                  st_d.mask = st_q.wdata[6:0];
               end
            end
            LSEG_IDX_EDGE_SEL: begin
               if (st_q.wstrb[0]) begin
                  st_d.edge_sel = st_q.wdata[6:0];
               end
            end
            LSEG_IDX_CTRL: begin
               if (st_q.wstrb[0]) begin
                  st_d.auto_remote_loop_enable = st_q.wdata[LSEG_CTRL_AUTO_REMOTE_LOOP_ENABLE];
               end
            end
            LSEG_IDX_STATUS, LSEG_IDX_INT_STATUS: begin
               // Read-only: write ignored
               st_d.bresp = LSEG_RESP_OKAY;
            end
            default: begin
               st_d.bresp = LSEG_RESP_SLVERR;
            end
         endcase
      end else if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // Read channel: one outstanding read, answered the next cycle
      // Read data is captured at the handshake, so a status bit that moves
      // while rvalid waits for rready cannot tear the answer.
      ar_hs = s_axi_arvalid && !st_q.rvalid;
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (ar_hs) begin
         ridx = s_axi_araddr[ADDR_W-1:2];
         st_d.rvalid = 1'b1;
         st_d.rresp = LSEG_RESP_OKAY;
         st_d.rdata = 32'h0000_0000;
         case (ridx)
            LSEG_IDX_MASK: begin
               st_d.rdata[6:0] = st_q.mask;
            end
            LSEG_IDX_EDGE_SEL: begin
               st_d.rdata[6:0] = st_q.edge_sel;
            end
            LSEG_IDX_STATUS: begin
               st_d.rdata[6:0] = st_q.status;
            end
            LSEG_IDX_INT_STATUS: begin
               st_d.rdata[6:0] = st_q.int_status;
               st_d.int_status = 7'h00;
            end
            LSEG_IDX_CTRL: begin
               st_d.rdata[LSEG_CTRL_AUTO_REMOTE_LOOP_ENABLE] = st_q.auto_remote_loop_enable;
               st_d.rdata[LSEG_CTRL_RLP] = st_q.rloop;
            end
            default: begin
               st_d.rresp = LSEG_RESP_SLVERR;
            end
         endcase
      end

      // New events win over a clearing read in the same cycle, so no event
      // is lost between a read and the next one
      st_d.int_status = st_d.int_status | event_v;
   end

   // Synchronous reset returns every field, synchronisers included, to idle,
   // so the first cycles after release see no false edge.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q <= LSEG_STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Readies are decoded straight from state; valids and data come from flops.
   // A master therefore sees a ready drop in the cycle after its handshake.
   assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
   assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   // Latched bits were unmasked when set; re-gating lets a later mask silence them
   assign irq = |(st_q.int_status & ~st_q.mask);
   assign remote_loop_active = st_q.rloop;
   assign line_status = st_q.status;

endmodule
`default_nettype wire

// file: bench/lseg_assertions.sv
// Port checker for lseg_top, bound at the foot of this file.
// Assumes the bench holds detector pins low through reset.
`timescale 1ns/1ns
`default_nettype none
module lseg_checker
   import lseg_pkg::*;
#(parameter int ADDR_W = 8) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pattern_sync_in,
   input wire logic transmit_clock,
   input wire logic driver_short_in,
   input wire logic alarm_indication_in,
   input wire logic receive_line_pair_loss,
   input wire logic irq,
   input wire logic remote_loop_active,
   input wire logic [6:0] line_status
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----
   // Age since reset, and cycles since the transmit clock pin last moved
   // ----
   logic [2:0] age_q;
   logic [6:0] idle_q;
   logic tc_q;
   always_ff @(posedge clk) begin
      tc_q <= transmit_clock;
      if (!resetn) begin
         age_q <= 3'h0;
         idle_q <= 7'h00;
      end else begin
         if (age_q != 3'h4) age_q <= age_q + 3'h1;
         idle_q <= (transmit_clock != tc_q) ? 7'h00 : idle_q + {6'h00, idle_q != 7'h64};
      end
   end
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_pins_to_status: assert property (age_q == 3'h4 |->
      {line_status[4], line_status[2:0]} == {$past(pattern_sync_in, 3), $past(driver_short_in, 3),
      $past(alarm_indication_in, 3), $past(receive_line_pair_loss, 3)}) else $error("status lags pins");
   a_transmit_clock_lost: assert property (idle_q > 7'd80 |-> line_status[3]) else $error("clock loss missed");
   a_transmit_clock_seen: assert property (idle_q inside {[7'd6:7'd60]} |-> !line_status[3]) else $error("false loss");
   a_irq_quiet: assert property ($rose(resetn) |-> !irq [*3]) else $error("irq after reset");
   a_loop_on: assert property ($rose(line_status[6]) && !$rose(line_status[5]) |->
      ##[0:2] remote_loop_active) else $error("loop not closed");
   a_loop_off: assert property ($rose(line_status[5]) |-> ##[0:2] !remote_loop_active) else $error("loop open");
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("no read response");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved");
   a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_status_read: assert property (s_rd_taken ##0 (s_axi_araddr[7:2] == LSEG_IDX_STATUS) |=>
      s_axi_rdata == {25'h0, $past(line_status)}) else $error("status read wrong");
endmodule
bind lseg_top lseg_checker #(.ADDR_W(ADDR_W)) lseg_checker_inst (.clk, .resetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pattern_sync_in, .transmit_clock, .driver_short_in,
   .alarm_indication_in, .receive_line_pair_loss, .irq, .remote_loop_active, .line_status);
`default_nettype wire

// file: bench/lseg_tb_top.sv
// Self-checking bench for lseg_top over AXI4-Lite and detector pins.
// Assumes short qualification counts so code detection fits the run.
`timescale 1ns/1ns
`default_nettype none
module lseg_tb_top;
   import lseg_pkg::*;
   localparam logic [7:0] A_MASK = {LSEG_IDX_MASK, 2'b00};
   localparam logic [7:0] A_ES = {LSEG_IDX_EDGE_SEL, 2'b00};
   localparam logic [7:0] A_ST = {LSEG_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_INT = {LSEG_IDX_INT_STATUS, 2'b00};
   localparam logic [7:0] A_CTL = {LSEG_IDX_CTRL, 2'b00};
   localparam logic [1:0] OK = LSEG_RESP_OKAY;
   logic clk, resetn, ber, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, rla;
   logic [6:0] pin, ls;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   int err_count, checked;
   lseg_top #(.QUAL_SHORT_CYCLES(20), .QUAL_LONG_CYCLES(50)) lseg_top_inst (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .activate_code_seen(pin[6]), .deactivate_code_seen(pin[5]),
      .code_error_rate_high(ber), .pattern_sync_in(pin[4]), .transmit_clock(pin[3]), .driver_short_in(pin[2]),
      .alarm_indication_in(pin[1]), .receive_line_pair_loss(pin[0]), .irq(irq), .remote_loop_active(rla),
      .line_status(ls));
   // ----
   // Compares, waits and bus cycles
   // ----
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin err_count++; $display("unexpected at %0t: word %h, want %h", $time, g, e); end
   endtask
   task automatic chk1(input logic g, input logic e);
      checked++;
      if (g !== e) begin err_count++; $display("unexpected at %0t: flag %b, want %b", $time, g, e); end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic setp(input int i, input logic v);
      @(posedge clk) pin[i] <= v;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      for (int n = 0; n < 20 && !tb; n++) begin
         @(negedge clk);
         ta = awv && awr; tw = wv && wrd; tb = bv;
         if (tb) chk(32'(bresp), 32'(er));
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      br <= 1'b0;
      chk1(tb, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      araddr <= a; arv <= 1'b1; rr <= 1'b1;
      for (int n = 0; n < 20 && !tr; n++) begin
         @(negedge clk);
         ta = arv && arr; tr = rv;
         if (tr) begin chk(rdata, e); chk(32'(rresp), 32'(er)); end
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end
      rr <= 1'b0;
      chk1(tr, 1'b1);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_regs;
      rd(A_ST, 0, OK);
      rd(A_MASK, 32'h7f, OK);
      rd(A_ES, 0, OK);
      wr(A_ES, 32'hff, OK);
      rd(A_ES, 32'h7f, OK);
      wt(90);
      wr(A_ST, 32'h7f, OK);
      rd(A_ST, 32'h08, OK);
      wr(8'h44, 1, LSEG_RESP_SLVERR);
      rd(8'h44, 0, LSEG_RESP_SLVERR);
      $display("t_regs done");
   endtask
   task automatic t_edges;
      int src [4] = '{0, 1, 2, 4};
      setp(0, 1'b1); wt(8); chk1(irq, 1'b0);
      rd(A_INT, 0, OK);
      setp(0, 1'b0); wt(8);
      wr(A_MASK, 0, OK);
      for (int s = 0; s < 2; s++) begin
         wr(A_ES, s ? 32'h7f : 0, OK);
         foreach (src[k]) begin
            setp(src[k], 1'b1); wt(6);
            chk1(ls[src[k]], 1'b1);
            chk1(irq, 1'b1);
            rd(A_INT, 32'h1 << src[k], OK);
            wt(1); chk1(irq, 1'b0);
            setp(src[k], 1'b0); wt(6);
            chk1(irq, s[0]);
            rd(A_INT, 32'(s) << src[k], OK);
         end
      end
      $display("t_edges done");
   endtask
   task automatic t_transmit_clock;
      for (int n = 0; n < 10; n++) setp(3, ~pin[3]);
      wt(6); chk1(ls[3], 1'b0);
      rd(A_INT, 32'h08, OK);
      wt(55); chk1(ls[3], 1'b0);
      wt(20); chk1(ls[3], 1'b1);
      rd(A_INT, 32'h08, OK);
      $display("t_transmit_clock done");
   endtask
   task automatic t_codes;
      setp(6, 1'b1); wt(15); chk1(ls[6], 1'b0);
      wt(15); chk1(ls[6], 1'b1);
      chk1(rla, 1'b1);
      rd(A_INT, 32'h40, OK);
      setp(6, 1'b0); wt(10); chk1(ls[6], 1'b1);
      @(posedge clk) ber <= 1'b1;
      wt(6); chk1(ls[6], 1'b0);
      @(posedge clk) ber <= 1'b0;
      setp(5, 1'b1); wt(30); chk1(ls[5], 1'b1);
      chk1(rla, 1'b0);
      setp(5, 1'b0);
      @(posedge clk) ber <= 1'b1;
      wt(6);
      @(posedge clk) ber <= 1'b0;
      rd(A_INT, 32'h60, OK);
      wr(A_CTL, 1, OK);
      setp(6, 1'b1); wt(45); chk1(ls[6], 1'b0);
      wt(20); chk1(ls[6], 1'b1);
      $display("t_codes done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("unexpected at %0t: run hung", $time);
      report_and_stop();
   end
   initial begin
      resetn = 1'b0; ber = 1'b0; pin = 7'h00; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; err_count = 0; checked = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_edges();
      t_transmit_clock();
      t_codes();
      report_and_stop();
   end
endmodule
`default_nettype wire
